// ---- common/adc_cfg_pkg.sv ----
package adc_cfg_pkg;

  // Serial command layout.
  localparam int CMD_LEN = 16;
  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;
  localparam int CNT_W = 5;
  localparam logic [4:0] CNT_ADDR_DONE = 5'h08;
  localparam logic [4:0] CNT_FULL = 5'h10;

  // Register addresses.
  localparam logic [6:0] ADDR_SOFT_RESET = 7'h00;
  localparam logic [6:0] ADDR_POWER_DOWN = 7'h01;
  localparam logic [6:0] ADDR_CLK_TIMING = 7'h02;
  localparam logic [6:0] ADDR_DRIVE_MODE = 7'h03;

  // Field positions.
  localparam int RST_BIT = 7;
  localparam int PD_LSB = 0;
  localparam int DCS_BIT = 0;
  localparam int PHASE_LSB = 1;
  localparam int INV_BIT = 3;
  localparam int FMT_LSB = 0;
  localparam int OFF_BIT = 2;
  localparam int TERM_BIT = 3;
  localparam int DRIVE_LSB = 4;

  // Reset value and the bits each register keeps.
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] PD_MASK = 8'h03;
  localparam logic [7:0] TIM_MASK = 8'h0F;
  localparam logic [7:0] OUT_MASK = 8'h7F;

  typedef enum logic [1:0] {
    PD_NORMAL = 2'h0,
    PD_NAP = 2'h1,
    PD_UNUSED = 2'h2,
    PD_SLEEP = 2'h3
  } power_down_code_t;

  typedef enum logic [1:0] {
    FMT_CMOS_FULL = 2'h0,
    FMT_LVDS_DDR = 2'h1,
    FMT_CMOS_DDR = 2'h2,
    FMT_UNUSED = 2'h3
  } output_format_t;

  localparam logic [2:0] DRIVE_DEFAULT = 3'h0;
  localparam logic [2:0] INV_EIGHTHS = 3'h4;

  // Driver current in microamps per drive code; termination scales by 8/5.
  localparam logic [12:0] UA_3500 = 13'h0DAC;
  localparam logic [12:0] UA_4000 = 13'h0FA0;
  localparam logic [12:0] UA_4500 = 13'h1194;
  localparam logic [12:0] UA_3000 = 13'h0BB8;
  localparam logic [12:0] UA_2500 = 13'h09C4;
  localparam logic [12:0] UA_2100 = 13'h0834;
  localparam logic [12:0] UA_1750 = 13'h06D6;
  localparam logic [12:0] UA_NONE = 13'h0000;
  localparam logic [15:0] TERM_NUM = 16'h0008;
  localparam logic [15:0] TERM_DEN = 16'h0005;

  typedef struct packed {
    logic rw;
    logic [6:0] addr;
    logic [7:0] data;
  } cmd_word_t;

  typedef struct packed {
    logic [7:0] drive_mode;
    logic [7:0] timing;
    logic [7:0] power;
  } mode_regs_t;

  typedef struct packed {
    logic duty_stabilizer_enable;
    output_format_t fmt;
    power_down_code_t pd;
    logic [2:0] drive;
    logic term;
    logic off;
    logic inv;
    logic [1:0] phase;
  } mode_cfg_t;

endpackage

// ---- hw/serial_cmd_link.sv ----
`timescale 1ns/1ps
// Link-side shifter. Counter and readback run only while chip select is low; the word register shifts on serial clock edges whatever chip select is.
module serial_cmd_link #(
  parameter int CMD_BITS = adc_cfg_pkg::CMD_LEN
) (
  input wire logic sck_i,
  input wire logic cs_n_i,
  input wire logic sdi_i,
  input adc_cfg_pkg::mode_regs_t regs_i,
  output adc_cfg_pkg::cmd_word_t word_o,
  output logic word_full_o,
  output logic sdo_o,
  output logic sdo_oe_o
);

  if (CMD_BITS != adc_cfg_pkg::CMD_LEN) begin : g_chk
    $error("serial_cmd_link: command length must be 16");
  end

  typedef struct packed {
    logic [4:0] cnt;
  } cnt_st_t;

  typedef struct packed {
    logic [15:0] word;
    logic full;
  } dat_st_t;

  typedef struct packed {
    logic active;
    logic [7:0] sh;
  } out_st_t;

  cnt_st_t c_q, c_d;
  dat_st_t w_q, w_d;
  out_st_t o_q, o_d;

  function automatic logic [7:0] read_reg(input logic [6:0] a,
                                          input adc_cfg_pkg::mode_regs_t r);
    case (a)
      adc_cfg_pkg::ADDR_POWER_DOWN: read_reg = r.power;
      adc_cfg_pkg::ADDR_CLK_TIMING: read_reg = r.timing;
      adc_cfg_pkg::ADDR_DRIVE_MODE: read_reg = r.drive_mode;
      default: read_reg = adc_cfg_pkg::REG_RESET;
    endcase
  endfunction

  always_comb begin
    c_d = c_q;
    w_d = w_q;
    if (c_q.cnt != adc_cfg_pkg::CNT_FULL) begin
      c_d.cnt = c_q.cnt + 5'h01;
      w_d.word = {w_q.word[14:0], sdi_i};
    end
    w_d.full = (c_d.cnt == adc_cfg_pkg::CNT_FULL);
  end

  // Chip select high ends the frame and rearms the bit counter.
  always_ff @(posedge sck_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      c_q <= '0;
    end else begin
      c_q <= c_d;
    end
  end

  // The word is left unreset so the core can collect it after the frame.
  always_ff @(posedge sck_i) begin
    w_q <= w_d;
  end

  // Readback is launched on falling edges so the host samples on rising.
  always_comb begin
    o_d = o_q;
    if (c_q.cnt == adc_cfg_pkg::CNT_ADDR_DONE && w_q.word[7]) begin
      o_d.active = 1'b1;
      o_d.sh = read_reg(w_q.word[6:0], regs_i);
    end else if (c_q.cnt == adc_cfg_pkg::CNT_FULL) begin
      o_d.active = 1'b0;
    end else if (o_q.active && c_q.cnt > adc_cfg_pkg::CNT_ADDR_DONE) begin
      o_d.sh = {o_q.sh[6:0], 1'b1};
    end
  end

  always_ff @(negedge sck_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      o_q <= '0;
    end else begin
      o_q <= o_d;
    end
  end

  assign word_o = adc_cfg_pkg::cmd_word_t'(w_q.word);
  assign word_full_o = w_q.full;
  assign sdo_o = 1'b0;
  assign sdo_oe_o = o_q.active & ~o_q.sh[7];

endmodule // serial_cmd_link

// ---- hw/adc_mode_config_port.sv ----
`timescale 1ns/1ps
// Overview of operation
// - Parallel mode: chip select sets duty stabilizer.
// - Parallel mode: serial clock selects output format.
// - Parallel mode: serial data in selects sleep.
// - Serial mode: pins form register programming port.
// - Chip select low frames one command.
// - Sample first sixteen rising edges, ignore rest.
// - Word is flag, seven address, eight data.
// - Flag low writes data to addressed register.
// - Flag high reads back, register unchanged.
// - Readback line is open drain.
// - Reset bit clears all registers, self-clears.
// - Reset register write only, low bits ignored.
// - Power code: normal, nap, sleep.
// - Timing bit three inverts output clock.
// - Phase field delays clock by eighths.
// - Timing bit zero switches duty stabilizer.
// - Drive field selects LVDS driver current.
// - Termination bit enables termination, scales current.
// - Disable bit floats all digital outputs.
// - Format field selects CMOS or LVDS mode.
module adc_mode_config_port #(
  parameter int ADDR_BITS = adc_cfg_pkg::ADDR_W,
  parameter int DATA_BITS = adc_cfg_pkg::DATA_W
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic sck_i,
  input wire logic cs_n_i,
  input wire logic sdi_i,
  input wire logic interface_select_strap_i,
  output logic sdo_o,
  output logic sdo_oe_o,
  output logic serial_mode_o,
  output logic duty_stabilizer_enable_o,
  output adc_cfg_pkg::output_format_t output_format_select_o,
  output adc_cfg_pkg::power_down_code_t power_down_code_o,
  output logic nap_o,
  output logic sleep_o,
  output logic out_clock_invert_o,
  output logic [1:0] out_clock_phase_delay_o,
  output logic [2:0] out_clock_delay_eighths_o,
  output logic [2:0] lvds_drive_current_o,
  output logic lvds_termination_enable_o,
  output logic [12:0] lvds_current_ua_o,
  output logic output_disable_o,
  output logic outputs_driven_o,
  output logic lvds_active_o,
  output logic ddr_active_o
);

  if (ADDR_BITS != adc_cfg_pkg::ADDR_W ||
      DATA_BITS != adc_cfg_pkg::DATA_W) begin : g_chk
    $error("adc_mode_config_port: 7 address and 8 data bits only");
  end

  typedef struct packed {
    logic strap_s1;
    logic strap_s2;
    logic csn_s1;
    logic csn_s2;
    logic csn_s3;
    logic sck_s1;
    logic sck_s2;
    logic sdi_s1;
    logic sdi_s2;
    adc_cfg_pkg::mode_regs_t regs;
    adc_cfg_pkg::mode_cfg_t cfg;
    logic [2:0] delay8;
    logic [12:0] ua;
    logic driven;
    logic lvds;
    logic ddr;
  } state_t;

  state_t s_q, s_d;

  adc_cfg_pkg::cmd_word_t link_word;
  logic link_full;
  logic frame_end;
  logic serial_mode;
  logic link_oe;
  adc_cfg_pkg::mode_cfg_t cfg_next;

  // The link presents the registers while a frame runs. The core only
  // changes them after the frame has ended, so they are stable for every
  // readback bit; a handshake would not fit in the eight link periods.
  serial_cmd_link #(
    .CMD_BITS(adc_cfg_pkg::CMD_LEN)
  ) u_link (
    .sck_i(sck_i),
    .cs_n_i(cs_n_i),
    .sdi_i(sdi_i),
    .regs_i(s_q.regs),
    .word_o(link_word),
    .word_full_o(link_full),
    .sdo_o(sdo_o),
    .sdo_oe_o(link_oe)
  );

  // Base driver current for a drive code, zero for the unused code.
  function automatic logic [12:0] drive_ua(input logic [2:0] code);
    case (code)
      3'h0: drive_ua = adc_cfg_pkg::UA_3500;
      3'h1: drive_ua = adc_cfg_pkg::UA_4000;
      3'h2: drive_ua = adc_cfg_pkg::UA_4500;
      3'h4: drive_ua = adc_cfg_pkg::UA_3000;
      3'h5: drive_ua = adc_cfg_pkg::UA_2500;
      3'h6: drive_ua = adc_cfg_pkg::UA_2100;
      3'h7: drive_ua = adc_cfg_pkg::UA_1750;
      default: drive_ua = adc_cfg_pkg::UA_NONE;
    endcase
  endfunction

  // Effective current; the termination multiplies by 8/5.
  function automatic logic [12:0] eff_ua(input logic [2:0] code,
                                         input logic term);
    logic [15:0] base;
    logic [15:0] scaled;
    base = {3'h0, drive_ua(code)};
    scaled = base * adc_cfg_pkg::TERM_NUM / adc_cfg_pkg::TERM_DEN;
    if (term) begin
      eff_ua = scaled[12:0];
    end else begin
      eff_ua = base[12:0];
    end
  endfunction

  // Total output clock delay in eighths of a period; inversion is four.
  function automatic logic [2:0] delay_eighths(input logic [1:0] phase,
                                               input logic inv);
    logic [2:0] d;
    d = {1'b0, phase};
    if (inv) begin
      d = d + adc_cfg_pkg::INV_EIGHTHS;
    end
    delay_eighths = d;
  endfunction

  // Decode the serial registers into the mode settings.
  function automatic adc_cfg_pkg::mode_cfg_t from_regs(
      input adc_cfg_pkg::mode_regs_t r);
    adc_cfg_pkg::mode_cfg_t c;
    c.pd = adc_cfg_pkg::power_down_code_t'(
        r.power[adc_cfg_pkg::PD_LSB +: 2]);
    c.duty_stabilizer_enable = r.timing[adc_cfg_pkg::DCS_BIT];
    c.phase = r.timing[adc_cfg_pkg::PHASE_LSB +: 2];
    c.inv = r.timing[adc_cfg_pkg::INV_BIT];
    c.fmt = adc_cfg_pkg::output_format_t'(
        r.drive_mode[adc_cfg_pkg::FMT_LSB +: 2]);
    c.off = r.drive_mode[adc_cfg_pkg::OFF_BIT];
    c.term = r.drive_mode[adc_cfg_pkg::TERM_BIT];
    c.drive = r.drive_mode[adc_cfg_pkg::DRIVE_LSB +: 3];
    from_regs = c;
  endfunction

  // Parallel mode settings from the three pin levels.
  function automatic adc_cfg_pkg::mode_cfg_t from_pins(
      input logic csn, input logic sck, input logic sdi);
    adc_cfg_pkg::mode_cfg_t c;
    c = '0;
    c.duty_stabilizer_enable = csn;
    if (sck) begin
      c.fmt = adc_cfg_pkg::FMT_LVDS_DDR;
    end else begin
      c.fmt = adc_cfg_pkg::FMT_CMOS_FULL;
    end
    c.drive = adc_cfg_pkg::DRIVE_DEFAULT;
    c.term = 1'b0;
    if (sdi) begin
      c.pd = adc_cfg_pkg::PD_SLEEP;
    end else begin
      c.pd = adc_cfg_pkg::PD_NORMAL;
    end
    from_pins = c;
  endfunction

  assign serial_mode = ~s_q.strap_s2;
  assign frame_end = s_q.csn_s2 & ~s_q.csn_s3;

  // In parallel mode the pins are static levels, so the data line stays
  // released whatever the link happens to count. The strap is static, so
  // this gate does not glitch the line during a frame.
  assign sdo_oe_o = link_oe & serial_mode;

  always_comb begin
    s_d = s_q;
    // Every pin passes two flip-flops before the core looks at it.
    s_d.strap_s1 = interface_select_strap_i;
    s_d.strap_s2 = s_q.strap_s1;
    s_d.csn_s1 = cs_n_i;
    s_d.csn_s2 = s_q.csn_s1;
    s_d.csn_s3 = s_q.csn_s2;
    s_d.sck_s1 = sck_i;
    s_d.sck_s2 = s_q.sck_s1;
    s_d.sdi_s1 = sdi_i;
    s_d.sdi_s2 = s_q.sdi_s1;

    // A finished word is acted on once chip select has gone high, when the
    // link has stopped and its word no longer moves. Short frames are
    // dropped. Unmapped addresses take no effect.
    if (serial_mode && frame_end && link_full) begin
      if (!link_word.rw) begin
        case (link_word.addr)
          adc_cfg_pkg::ADDR_SOFT_RESET: begin
            // Only bit 7 acts; it is never stored, so it reads as clear
            // once the command is complete.
            if (link_word.data[adc_cfg_pkg::RST_BIT]) begin
              s_d.regs.power = adc_cfg_pkg::REG_RESET;
              s_d.regs.timing = adc_cfg_pkg::REG_RESET;
              s_d.regs.drive_mode = adc_cfg_pkg::REG_RESET;
            end
          end
          adc_cfg_pkg::ADDR_POWER_DOWN: begin
            s_d.regs.power = link_word.data & adc_cfg_pkg::PD_MASK;
          end
          adc_cfg_pkg::ADDR_CLK_TIMING: begin
            s_d.regs.timing = link_word.data & adc_cfg_pkg::TIM_MASK;
          end
          adc_cfg_pkg::ADDR_DRIVE_MODE: begin
            s_d.regs.drive_mode = link_word.data & adc_cfg_pkg::OUT_MASK;
          end
          default: begin
            s_d.regs = s_q.regs;
          end
        endcase
      end
    end

    // Outputs follow the registers in serial mode, the pins otherwise.
    if (serial_mode) begin
      cfg_next = from_regs(s_q.regs);
    end else begin
      cfg_next = from_pins(s_q.csn_s2, s_q.sck_s2, s_q.sdi_s2);
    end
    s_d.cfg = cfg_next;
    s_d.delay8 = delay_eighths(cfg_next.phase, cfg_next.inv);
    s_d.ua = eff_ua(cfg_next.drive, cfg_next.term);
    s_d.driven = ~cfg_next.off;
    s_d.lvds = (cfg_next.fmt == adc_cfg_pkg::FMT_LVDS_DDR);
    s_d.ddr = (cfg_next.fmt == adc_cfg_pkg::FMT_LVDS_DDR) ||
              (cfg_next.fmt == adc_cfg_pkg::FMT_CMOS_DDR);
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_q <= '0;
      // Chip select idles high; starting its synchronisers there keeps the
      // release of reset from looking like the end of a frame.
      s_q.csn_s1 <= 1'b1;
      s_q.csn_s2 <= 1'b1;
      s_q.csn_s3 <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign serial_mode_o = serial_mode;
  assign duty_stabilizer_enable_o = s_q.cfg.duty_stabilizer_enable;
  assign output_format_select_o = s_q.cfg.fmt;
  assign power_down_code_o = s_q.cfg.pd;
  assign nap_o = (s_q.cfg.pd == adc_cfg_pkg::PD_NAP);
  assign sleep_o = (s_q.cfg.pd == adc_cfg_pkg::PD_SLEEP);
  assign out_clock_invert_o = s_q.cfg.inv;
  assign out_clock_phase_delay_o = s_q.cfg.phase;
  assign out_clock_delay_eighths_o = s_q.delay8;
  assign lvds_drive_current_o = s_q.cfg.drive;
  assign lvds_termination_enable_o = s_q.cfg.term;
  assign lvds_current_ua_o = s_q.ua;
  assign output_disable_o = s_q.cfg.off;
  assign outputs_driven_o = s_q.driven;
  assign lvds_active_o = s_q.lvds;
  assign ddr_active_o = s_q.ddr;

endmodule // adc_mode_config_port

// ---- tb/adc_mode_config_port_assertions.sv ----
`timescale 1ns/1ps
module adc_mode_config_port_assertions (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic sck_i,
  input wire logic cs_n_i,
  input wire logic sdi_i,
  input wire logic interface_select_strap_i,
  input logic sdo_oe_o,
  input logic serial_mode_o,
  input logic duty_stabilizer_enable_o,
  input adc_cfg_pkg::output_format_t output_format_select_o,
  input adc_cfg_pkg::power_down_code_t power_down_code_o,
  input logic nap_o,
  input logic sleep_o,
  input logic out_clock_invert_o,
  input logic [1:0] out_clock_phase_delay_o,
  input logic [2:0] out_clock_delay_eighths_o,
  input logic [2:0] lvds_drive_current_o,
  input logic lvds_termination_enable_o,
  input logic output_disable_o,
  input logic outputs_driven_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);
  sequence par_held(logic pin);
    (interface_select_strap_i && pin)[*5];
  endsequence
  sequence ser_frame;
    (!interface_select_strap_i && !cs_n_i)[*6];
  endsequence
  chk_par_stab_on: assert property (par_held(cs_n_i) |->
    duty_stabilizer_enable_o) else $error("stabilizer not on");
  chk_par_stab_off: assert property (par_held(!cs_n_i) |->
    !duty_stabilizer_enable_o) else $error("stabilizer not off");
  chk_par_format: assert property (par_held(sck_i) |->
    output_format_select_o == adc_cfg_pkg::FMT_LVDS_DDR &&
    lvds_drive_current_o == 3'h0 && !lvds_termination_enable_o)
    else $error("parallel format wrong");
  chk_par_sleep: assert property (par_held(sdi_i) |->
    power_down_code_o == adc_cfg_pkg::PD_SLEEP) else $error("no sleep");
  chk_mode_flag: assert property (
    $stable(interface_select_strap_i)[*5] |->
    serial_mode_o != interface_select_strap_i) else $error("mode flag");
  chk_sdo_released: assert property (cs_n_i |-> !sdo_oe_o)
    else $error("data line held outside frame");
  chk_frame_quiet: assert property (ser_frame |->
    $stable({out_clock_invert_o, out_clock_phase_delay_o,
    lvds_drive_current_o, power_down_code_o}))
    else $error("settings changed inside a frame");
  chk_pd_decode: assert property (
    $stable(power_down_code_o)[*3] |->
    nap_o == (power_down_code_o == adc_cfg_pkg::PD_NAP) &&
    sleep_o == (power_down_code_o == adc_cfg_pkg::PD_SLEEP))
    else $error("power decode wrong");
  chk_clk_eighths: assert property (
    $stable({out_clock_invert_o, out_clock_phase_delay_o})[*3] |->
    out_clock_delay_eighths_o ==
    {out_clock_invert_o, out_clock_phase_delay_o})
    else $error("clock delay wrong");
  chk_out_driven: assert property ($stable(output_disable_o)[*3] |->
    outputs_driven_o != output_disable_o) else $error("drive flag wrong");
endmodule // adc_mode_config_port_assertions

bind adc_mode_config_port adc_mode_config_port_assertions u_chk (
  .clk_i, .nrst_i, .sck_i, .cs_n_i, .sdi_i, .interface_select_strap_i,
  .sdo_oe_o, .serial_mode_o, .duty_stabilizer_enable_o,
  .output_format_select_o, .power_down_code_o, .nap_o, .sleep_o,
  .out_clock_invert_o, .out_clock_phase_delay_o, .out_clock_delay_eighths_o,
  .lvds_drive_current_o, .lvds_termination_enable_o, .output_disable_o,
  .outputs_driven_o
);

// ---- tb/spi_host_model.sv ----
`timescale 1ns/1ps
module spi_host_model (
  input wire logic go_i,
  input wire logic [15:0] word_i,
  input wire logic [4:0] edges_i,
  input wire logic sdo_line_i,
  output logic cs_n_o,
  output logic sck_o,
  output logic sdi_o,
  output logic [7:0] rdata_o,
  output logic done_o
);
  int i;
  initial begin
    cs_n_o = 1'b1;
    sck_o = 1'b0;
    sdi_o = 1'b0;
    rdata_o = 8'h00;
    done_o = 1'b0;
    forever begin
      wait (go_i);
      cs_n_o = 1'b0;
      #20;
      for (i = 0; i < edges_i; i++) begin
        // Past the word the host keeps clocking ones, which must be dropped.
        sdi_o = (i < 16) ? word_i[15 - i] : 1'b1;
        #16 sck_o = 1'b1;
        if (i >= 8 && i < 16) rdata_o[15 - i] = sdo_line_i;
        #16 sck_o = 1'b0;
      end
      #20 cs_n_o = 1'b1;
      sdi_o = ~sdi_o;
      done_o = 1'b1;
      wait (!go_i);
      done_o = 1'b0;
    end
  end
endmodule // spi_host_model

// ---- tb/adc_mode_config_port_tb.sv ----
`timescale 1ns/1ps
module adc_mode_config_port_tb;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic interface_select_strap_i = 1'b0;
  logic go = 1'b0;
  logic [15:0] word = 16'h0000;
  logic [4:0] edges = 5'h10;
  logic [2:0] par = 3'h0;
  logic h_cs, h_sck, h_sdi, done, sdo_line, sck_i, cs_n_i, sdi_i;
  logic [7:0] rdata;
  logic sdo_o, sdo_oe_o, serial_mode_o, duty_stabilizer_enable_o, nap_o;
  logic sleep_o, out_clock_invert_o, lvds_termination_enable_o;
  logic output_disable_o, outputs_driven_o, lvds_active_o, ddr_active_o;
  logic [1:0] out_clock_phase_delay_o;
  logic [2:0] out_clock_delay_eighths_o, lvds_drive_current_o;
  logic [12:0] lvds_current_ua_o;
  adc_cfg_pkg::output_format_t output_format_select_o;
  adc_cfg_pkg::power_down_code_t power_down_code_o;
  int n_fail = 0;
  int comparisons = 0;
  logic [1:0] pdc [3] = '{2'h1, 2'h3, 2'h0};
  logic [7:0] tim [3] = '{8'h0F, 8'h05, 8'hF8};
  logic [12:0] uat [8] = '{adc_cfg_pkg::UA_3500, adc_cfg_pkg::UA_4000,
    adc_cfg_pkg::UA_4500, adc_cfg_pkg::UA_NONE, adc_cfg_pkg::UA_3000,
    adc_cfg_pkg::UA_2500, adc_cfg_pkg::UA_2100, adc_cfg_pkg::UA_1750};
  logic [7:0] d;
  int ua;

  always #12.5 clk_i = ~clk_i;
  // Open-drain line with the board pull-up.
  assign sdo_line = sdo_oe_o ? sdo_o : 1'b1;
  assign cs_n_i = interface_select_strap_i ? par[0] : h_cs;
  assign sck_i = interface_select_strap_i ? par[1] : h_sck;
  assign sdi_i = interface_select_strap_i ? par[2] : h_sdi;

  spi_host_model host (.go_i(go), .word_i(word), .edges_i(edges),
    .sdo_line_i(sdo_line), .cs_n_o(h_cs), .sck_o(h_sck), .sdi_o(h_sdi),
    .rdata_o(rdata), .done_o(done));

  adc_mode_config_port DUT (.clk_i, .nrst_i, .sck_i, .cs_n_i, .sdi_i,
    .interface_select_strap_i, .sdo_o, .sdo_oe_o, .serial_mode_o,
    .duty_stabilizer_enable_o, .output_format_select_o, .power_down_code_o,
    .nap_o, .sleep_o, .out_clock_invert_o, .out_clock_phase_delay_o,
    .out_clock_delay_eighths_o, .lvds_drive_current_o,
    .lvds_termination_enable_o, .lvds_current_ua_o, .output_disable_o,
    .outputs_driven_o, .lvds_active_o, .ddr_active_o);

  task automatic check(string what, logic [15:0] exp, logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic xfer(logic [15:0] w, logic [4:0] n = 5'h10);
    int k;
    @(posedge clk_i);
    #2;
    word = w;
    edges = n;
    go = 1'b1;
    for (k = 0; k < 200 && done !== 1'b1; k++) @(posedge clk_i);
    if (k == 200) n_fail++;
    #2 go = 1'b0;
    // Leaves the gap between frames and lets the update reach the outputs.
    repeat (8) @(posedge clk_i);
    #2;
  endtask

  task automatic rd(logic [6:0] a, logic [7:0] exp);
    xfer({1'b1, a, 8'hFF});
    check("readback", {8'h00, exp}, {8'h00, rdata});
  endtask

  task automatic results();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    #1000000;
    n_fail++;
    results();
  end

  initial begin
    repeat (5) @(posedge clk_i);
    #2 nrst_i = 1'b1;
    repeat (5) @(posedge clk_i);
    xfer(16'h0080);
    check("serial_mode", 16'h1, serial_mode_o);
    foreach (pdc[i]) begin
      xfer({8'h01, 6'h3F, pdc[i]});
      rd(7'h01, {6'h00, pdc[i]});
      check("power_down", pdc[i], power_down_code_o);
      check("nap", pdc[i] == 2'h1, nap_o);
      check("sleep", pdc[i] == 2'h3, sleep_o);
    end
    foreach (tim[i]) begin
      xfer({8'h02, tim[i]});
      rd(7'h02, tim[i] & 8'h0F);
      check("stabilizer", tim[i][0], duty_stabilizer_enable_o);
      check("phase", tim[i][2:1], out_clock_phase_delay_o);
      check("invert", tim[i][3], out_clock_invert_o);
      check("eighths", tim[i][3:1], out_clock_delay_eighths_o);
    end
    for (int i = 0; i < 8; i++) begin
      d = {1'b1, i[2:0], i[0], i[1], i[1:0]};
      ua = i[0] ? int'(uat[i]) * 8 / 5 : int'(uat[i]);
      xfer({8'h03, d});
      rd(7'h03, d & 8'h7F);
      check("drive", i[2:0], lvds_drive_current_o);
      check("current", ua[15:0], lvds_current_ua_o);
      check("term", i[0], lvds_termination_enable_o);
      check("disable", i[1], output_disable_o);
      check("driven", !i[1], outputs_driven_o);
      check("format", i[1:0], output_format_select_o);
      check("lvds", i[1:0] == 2'h1, lvds_active_o);
      check("ddr", i[1:0] == 2'h1 || i[1:0] == 2'h2, ddr_active_o);
    end
    xfer(16'h0103, 5'h14);
    check("long_frame", 16'h3, power_down_code_o);
    // Ends in a zero bit, so a kept short frame below would read as a reset.
    xfer(16'h0302);
    check("ddr_cmos", 16'h1, ddr_active_o);
    xfer(16'h0100, 5'h0F);
    check("short_frame", 16'h3, power_down_code_o);
    xfer(16'h007F);
    check("low_bits", 16'h3, power_down_code_o);
    rd(7'h00, 8'h00);
    xfer(16'h05FF);
    rd(7'h05, 8'h00);
    xfer(16'h0080);
    check("soft_reset", 16'h0, power_down_code_o);
    rd(7'h02, 8'h00);
    rd(7'h03, 8'h00);
    xfer(16'h0101);
    check("after_reset", 16'h1, power_down_code_o);
    interface_select_strap_i = 1'b1;
    for (int j = 0; j < 8; j++) begin
      par = j[2:0];
      repeat (6) @(posedge clk_i);
      #2;
      check("par_stab", j[0], duty_stabilizer_enable_o);
      check("par_format", j[1], output_format_select_o);
      check("par_drive", 16'h0, lvds_drive_current_o);
      check("par_sleep", j[2] ? 2'h3 : 2'h0, power_down_code_o);
      check("par_mode", 16'h0, serial_mode_o);
    end
    results();
  end
endmodule // adc_mode_config_port_tb
